// ===== nvc_ctrl.sv
// Command sequencer, register file and sleep keeper of the memory controller
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
// Functional notes
// - Erase-write: erase page, then program buffer
// - Halt CPU for every command except EEPROM page ops
// - Clear page buffer after erase-write
// - Buffer clear sets ones, halts seven cycles
// - Chip erase hits EEPROM unless preserve fuse
// - Chip erase ignores locks, leaves ones
// - EEPROM erase sets ones, halts CPU
// - Fuse write only from debug port
// - New fuse value effective after reset
// - Fuses readable by ordinary memory read
// - Reset aborts a running write
// - One EEPROM-ready interrupt source, flagged
// - Request while enabled and flag set
// - Controller sleeps with system when idle
// - Ongoing write keeps memory, clock running
// - Ready interrupt wakes from idle only
// - Page buffer cleared on wake-up
// - Command write needs key within four
// - Unkeyed command write leaves register unchanged
// - Three-bit command decode
// - Ready flag set while EEPROM idle, W1C
// - Status shows busy bits and error
module nvc_ctrl
    import nvc_pkg::*;
#(
    parameter int OP_CYCLES = ARRAY_OP_CYC
) (
    input  wire  logic        clk_sys,
    input  wire  logic        arst_n,
    input  wire  logic [3:0]  reg_addr,
    input  wire  logic [7:0]  reg_wdata,
    input  wire  logic        reg_wr,
    input  wire  logic        reg_rd,
    input  wire  logic        reg_from_dbg,
    output logic [7:0]        reg_rdata,
    input  wire  logic        key_wr,
    input  wire  logic [7:0]  key_data,
    input  wire  logic        cpu_insn,
    input  wire  logic        sys_sleep,
    input  wire  logic        sleep_idle,
    input  wire  logic        target_eeprom,
    input  wire  logic        target_protected,
    input  wire  logic        eeprom_preserve_fuse,
    output logic              cpu_halt,
    output logic              irq_req,
    output logic              wake_req,
    output logic              ctrl_asleep,
    output logic              keep_clk_on,
    output logic              arr_erase,
    output logic              arr_prog,
    output logic              arr_chip_flash,
    output logic              arr_chip_ee,
    output logic              arr_ee_all,
    output logic              pbuf_clear,
    output logic              fuse_wr,
    output logic [15:0]       fuse_addr,
    output logic [15:0]       fuse_wdata
);
    import nvc_pkg::*;

    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n_r;

    // Release through two flops; first flop feeds only the second
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [2:0]  cmd_r;
    logic        app_wp_r;
    logic        boot_lock_r;
    logic        irq_en_r;
    logic        ready_flag_r;
    logic        werr_r;
    logic [15:0] data_r;
    logic [15:0] addr_r;
    logic [2:0]  unlock_cnt_r;
    logic        on_ee_r;
    logic        halt_op_r;
    logic        was_asleep_r;
    logic [15:0] cnt_r;
    nvc_state_t  state_r;
    nvc_state_t  state_nxt;

    // Address decode for the plain register port
    wire wr_cmd    = reg_wr && (reg_addr == ADR_CMD_CTRL);
    wire wr_lock   = reg_wr && (reg_addr == ADR_LOCK_CTRL);
    wire wr_irq_en = reg_wr && (reg_addr == ADR_IRQ_EN);
    wire wr_flags  = reg_wr && (reg_addr == ADR_IRQ_FLAGS);
    wire idle      = (state_r == ST_IDLE);
    wire unlocked  = (unlock_cnt_r != 3'h0);
    // unkeyed or busy writes are dropped
    wire cmd_take  = wr_cmd && unlocked && idle;
    wire [2:0] cmd_in = reg_wdata[2:0];
    // fuse write refused from the CPU
    wire cmd_ok    = cmd_take && ((cmd_in != CMD_FUSE_WR) || reg_from_dbg);
    wire cnt_done  = (cnt_r == 16'h0001);
    wire ee_busy   = !idle && on_ee_r;
    wire fl_busy   = !idle && !on_ee_r;

    // ------------------------------------------------------------
    // Unlock window counter
    // ------------------------------------------------------------
    // Counts down one per retired CPU instruction after the key lands
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            unlock_cnt_r <= 3'h0;
        end else if (key_wr && key_data == SELF_PROG_KEY) begin
            unlock_cnt_r <= 3'(UNLOCK_WINDOW);
        end else if (cmd_take) begin
            unlock_cnt_r <= 3'h0;
        end else if (cpu_insn && unlocked) begin
            unlock_cnt_r <= unlock_cnt_r - 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    // Lock bits set only, cleared by reset alone
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            app_wp_r    <= 1'b0;
            boot_lock_r <= 1'b0;
            irq_en_r    <= 1'b0;
            data_r      <= 16'h0000;
            addr_r      <= 16'h0000;
        end else begin
            if (wr_lock) begin
                app_wp_r    <= app_wp_r | reg_wdata[BIT_APP_WP];
                boot_lock_r <= boot_lock_r | reg_wdata[BIT_BOOT_LOCK];
            end
            if (wr_irq_en) begin
                irq_en_r <= reg_wdata[BIT_EE_READY];
            end
            // debug port stages fuse address and data here
            if (reg_wr && reg_addr == ADR_DATA_LO) data_r[7:0]  <= reg_wdata;
            if (reg_wr && reg_addr == ADR_DATA_HI) data_r[15:8] <= reg_wdata;
            if (reg_wr && reg_addr == ADR_ADDR_LO) addr_r[7:0]  <= reg_wdata;
            if (reg_wr && reg_addr == ADR_ADDR_HI) addr_r[15:8] <= reg_wdata;
        end
    end

    // ready flag: set while EEPROM idle, set wins over W1C
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ready_flag_r <= 1'b0;
        end else if (!ee_busy && !(cmd_ok && target_eeprom)) begin
            ready_flag_r <= 1'b1;
        end else if (wr_flags && reg_wdata[BIT_EE_READY]) begin
            ready_flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    // decode the three-bit command field
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (cmd_ok) begin
                    case (cmd_in)
                        CMD_WRITE:      state_nxt = ST_PROG;
                        CMD_ERASE:      state_nxt = ST_ERASE;
                        CMD_ERASE_WR:   state_nxt = ST_ERASE;
                        CMD_BUF_CLR:    state_nxt = ST_CLEAR;
                        CMD_CHIP_ERASE: state_nxt = ST_CHIP;
                        CMD_EE_ERASE:   state_nxt = ST_CHIP;
                        CMD_FUSE_WR:    state_nxt = ST_FUSE;
                        default:        state_nxt = ST_IDLE;
                    endcase
                end
            end
            // erase-write moves on to programming, buffer kept
            ST_ERASE: if (cnt_done) state_nxt = (cmd_r == CMD_ERASE_WR) ? ST_PROG : ST_IDLE;
            ST_PROG:  if (cnt_done) state_nxt = ST_IDLE;
            ST_CLEAR: if (cnt_done) state_nxt = ST_IDLE;
            ST_CHIP:  if (cnt_done) state_nxt = ST_IDLE;
            ST_FUSE:  if (cnt_done) state_nxt = ST_IDLE;
            default:  state_nxt = ST_IDLE;
        endcase
    end

    // reset aborts whatever operation is running
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Step counter and command latch
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cnt_r     <= 16'h0000;
            cmd_r     <= CMD_NONE;
            on_ee_r   <= 1'b0;
            halt_op_r <= 1'b0;
            werr_r    <= 1'b0;
        end else if (idle && cmd_ok && cmd_in != CMD_NONE) begin
            cmd_r   <= cmd_in;
            cnt_r   <= (cmd_in == CMD_BUF_CLR) ? 16'(BUF_CLR_CYC) : 16'(OP_CYCLES);
            on_ee_r <= target_eeprom && (cmd_in <= CMD_ERASE_WR || cmd_in == CMD_EE_ERASE);
            // EEPROM page work runs with the CPU free
            halt_op_r <= !(target_eeprom && cmd_in <= CMD_ERASE_WR);
            // chip erase and buffer clear never see lock faults
            werr_r  <= target_protected && cmd_in <= CMD_ERASE_WR;
        end else if (state_r == ST_ERASE && cnt_done) begin
            cnt_r <= 16'(OP_CYCLES);
        end else if (!idle) begin
            cnt_r <= cnt_r - 16'h0001;
        end
    end

    // Command in force this cycle; the latch lags the accepting edge by one,
    // so strobes launched on that edge must look at the incoming code
    wire [2:0] cmd_cur = idle ? cmd_in : cmd_r;
    // Blocked page commands skip the erase and program strobes and report the error; the first
    // strobe needs the fresh verdict, not the one left by the last command
    wire do_op = idle ? !(target_protected && cmd_in <= CMD_ERASE_WR) : !werr_r;

    // ------------------------------------------------------------
    // Array strobes and outputs, all registered
    // ------------------------------------------------------------
    wire last_step = !idle && cnt_done && state_nxt == ST_IDLE;
    wire asleep_nxt = sys_sleep && idle;
    // level request while enabled and flagged
    wire irq_nxt = irq_en_r && ready_flag_r;

    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            arr_erase      <= 1'b0;
            arr_prog       <= 1'b0;
            arr_chip_flash <= 1'b0;
            arr_chip_ee    <= 1'b0;
            arr_ee_all     <= 1'b0;
            pbuf_clear     <= 1'b0;
            fuse_wr        <= 1'b0;
            fuse_addr      <= 16'h0000;
            fuse_wdata     <= 16'h0000;
            cpu_halt       <= 1'b0;
            irq_req        <= 1'b0;
            wake_req       <= 1'b0;
            ctrl_asleep    <= 1'b0;
            keep_clk_on    <= 1'b0;
            was_asleep_r   <= 1'b0;
        end else begin
            arr_erase <= state_nxt == ST_ERASE && do_op;
            arr_prog  <= state_nxt == ST_PROG && do_op;
            // chip erase: flash always, EEPROM unless preserved
            arr_chip_flash <= state_nxt == ST_CHIP && cmd_cur == CMD_CHIP_ERASE;
            arr_chip_ee    <= state_nxt == ST_CHIP && cmd_cur == CMD_CHIP_ERASE && !eeprom_preserve_fuse;
            arr_ee_all <= state_nxt == ST_CHIP && cmd_cur == CMD_EE_ERASE;
            // buffer to ones after page ops, clear, wake
            pbuf_clear <= (last_step && cmd_r != CMD_FUSE_WR && cmd_r != CMD_CHIP_ERASE
                           && cmd_r != CMD_EE_ERASE)
                          || (was_asleep_r && !sys_sleep);
            // fuse array latches new value for the next reset
            fuse_wr    <= state_nxt == ST_FUSE;
            // no fuse read command; reads use the plain memory map
            fuse_addr  <= addr_r;
            fuse_wdata <= data_r;
            // halt request held for the whole halting operation
            cpu_halt <= (state_nxt != ST_IDLE) && (idle ? (cmd_ok && !(target_eeprom && cmd_in <= CMD_ERASE_WR))
                                                       : halt_op_r);
            irq_req <= irq_nxt;
            // ready interrupt wakes from idle sleep only
            wake_req <= irq_nxt && sys_sleep && sleep_idle;
            // sleep with the system only when no write runs
            ctrl_asleep  <= asleep_nxt;
            was_asleep_r <= sys_sleep;
            // keep memory and system clock on until the write ends
            keep_clk_on <= sys_sleep && (state_nxt != ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Register read port, data one cycle after the strobe
    // ------------------------------------------------------------
    // busy bits and last-operation error
    wire [7:0] status_b = {5'h00, werr_r, ee_busy, fl_busy};
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            ADR_CMD_CTRL:  rd_mux = {5'h00, cmd_r};
            ADR_LOCK_CTRL: rd_mux = {6'h00, boot_lock_r, app_wp_r};
            ADR_STATUS:    rd_mux = status_b;
            ADR_IRQ_EN:    rd_mux = {7'h00, irq_en_r};
            ADR_IRQ_FLAGS: rd_mux = {7'h00, ready_flag_r};
            ADR_DATA_LO:   rd_mux = data_r[7:0];
            ADR_DATA_HI:   rd_mux = data_r[15:8];
            ADR_ADDR_LO:   rd_mux = addr_r[7:0];
            ADR_ADDR_HI:   rd_mux = addr_r[15:8];
            default:       rd_mux = RST_BYTE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            reg_rdata <= RST_BYTE;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : RST_BYTE;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_erase_done;
        state_r == ST_ERASE && cnt_done;
    endsequence

    a_erase_then_prog: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        s_erase_done and cmd_r == CMD_ERASE_WR |=> state_r == ST_PROG)
        else $error("erase-write did not move to programming");

    a_ee_no_halt: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        state_r == ST_PROG && on_ee_r |-> !cpu_halt)
        else $error("CPU halted during EEPROM write");

    a_clr_after_ew: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        state_r == ST_PROG && cnt_done && !werr_r |=> pbuf_clear)
        else $error("buffer not cleared after write");

    a_clr_seven: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        idle && cmd_ok && cmd_in == CMD_BUF_CLR |=> cpu_halt [*7] ##1 !cpu_halt)
        else $error("buffer clear halt not seven cycles");

    a_preserve_ee: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        eeprom_preserve_fuse && $stable(eeprom_preserve_fuse) |=> !arr_chip_ee)
        else $error("EEPROM erased despite preserve fuse");

    a_fuse_cpu: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        idle && wr_cmd && !reg_from_dbg && cmd_in == CMD_FUSE_WR |=> state_r != ST_FUSE)
        else $error("CPU started a fuse write");

    a_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        irq_en_r && ready_flag_r |=> irq_req)
        else $error("interrupt request missing");

    // Only idle cycles: a running command may end on its own in the next one
    a_no_key: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        wr_cmd && !unlocked && idle |=> $stable(cmd_r) && idle)
        else $error("unkeyed command write took effect");

    a_busy_flag: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
        ee_busy ##1 !ee_busy |=> ##[0:1] ready_flag_r)
        else $error("ready flag not set after EEPROM work");
endmodule : nvc_ctrl

// ===== nvc_ctrl_bench.sv
// Self-checking bench for the memory controller command block
`timescale 1ns/1ns
module nvc_ctrl_bench;
    import nvc_pkg::*;
    localparam int OP = 8;   // Short array step keeps the run brief
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic sys_sleep = 1'b0;
    logic sleep_idle = 1'b0;
    logic target_eeprom = 1'b0;
    logic target_protected = 1'b0;
    logic eeprom_preserve_fuse = 1'b0;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, key_data, st0;
    logic reg_wr, reg_rd, reg_from_dbg, key_wr, cpu_insn;
    logic cpu_halt, irq_req, wake_req, ctrl_asleep, keep_clk_on, fuse_wr;
    logic arr_erase, arr_prog, arr_chip_flash, arr_chip_ee, arr_ee_all, pbuf_clear;
    logic [15:0] fuse_addr, fuse_wdata;
    int num_errors = 0;
    int checks_done = 0;
    int cnt[8];
    int dl[8];
    always #5 clk_sys = ~clk_sys;
    nvc_ctrl #(.OP_CYCLES(OP)) nvc_ctrl_i (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_from_dbg, .reg_rdata, .key_wr, .key_data, .cpu_insn, .sys_sleep, .sleep_idle, .target_eeprom,
        .target_protected, .eeprom_preserve_fuse, .cpu_halt, .irq_req, .wake_req, .ctrl_asleep, .keep_clk_on,
        .arr_erase, .arr_prog, .arr_chip_flash, .arr_chip_ee, .arr_ee_all, .pbuf_clear, .fuse_wr, .fuse_addr,
        .fuse_wdata);
    nvc_host nvc_host_i (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_from_dbg, .reg_rdata,
        .key_wr, .key_data, .cpu_insn);
    // Cycle counts of every strobe; order: halt erase prog chipf chipee eeall pbc fuse
    always @(posedge clk_sys) begin
        for (int i = 0; i < 8; i++) begin
            cnt[i] <= cnt[i] + int'({fuse_wr, pbuf_clear, arr_ee_all, arr_chip_ee, arr_chip_flash,
                                     arr_prog, arr_erase, cpu_halt} >> i & 8'h01);
        end
    end
    // ------------------------------------------------------------
    // Shared checking tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out;
        $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    // Poll busy bits and halt; the first poll only records st0, the status while the command runs
    task automatic settle;
        logic [7:0] s;
        for (int i = 0; i < 40; i++) begin
            nvc_host_i.rd(ADR_STATUS, s);
            if (i == 0) begin
                st0 = s;
            end
            if (i > 0 && s[1:0] == 2'b00 && cpu_halt === 1'b0) begin
                repeat (2) @(posedge clk_sys);
                return;
            end
        end
        chk(1'b0, 1'b1);
        close_out();
    endtask : settle
    // Issue one command and judge which strobes moved
    task automatic op(input logic [2:0] c, input logic dbg, input int n, input logic [7:0] care,
                      input logic [7:0] want);
        int b[8];
        b = cnt;
        nvc_host_i.cmd(c, dbg, n);
        settle();
        for (int i = 0; i < 8; i++) begin
            dl[i] = cnt[i] - b[i];
            if (care[i]) begin
                chk(dl[i] != 0, want[i]);
            end
        end
    endtask : op
    task automatic t_regs;
        logic [7:0] v;
        logic [3:0] a[8] = '{ADR_CMD_CTRL, ADR_LOCK_CTRL, ADR_STATUS, ADR_IRQ_EN, 4'h5, ADR_DATA_LO,
                             ADR_ADDR_HI, 4'hf};
        nvc_host_i.wr(ADR_STATUS, 8'hff, 1'b0);
        for (int i = 0; i < 8; i++) begin
            nvc_host_i.rd(a[i], v);
            chk(v, RST_BYTE);
        end
        nvc_host_i.rd(ADR_IRQ_FLAGS, v);
        chk(v[BIT_EE_READY], 1'b1);
    endtask : t_regs
    task automatic t_key;
        logic [7:0] v;
        nvc_host_i.wr(ADR_CMD_CTRL, {5'h00, CMD_BUF_CLR}, 1'b0);
        op(CMD_BUF_CLR, 1'b0, UNLOCK_WINDOW, 8'hff, 8'h00);
        nvc_host_i.rd(ADR_CMD_CTRL, v);
        chk(v, 8'h00);
        op(CMD_NONE, 1'b0, 0, 8'hff, 8'h00);
        op(CMD_BUF_CLR, 1'b0, UNLOCK_WINDOW - 1, 8'hff, 8'h41);
        chk(dl[0], BUF_CLR_CYC);
        chk(dl[6], 1);
    endtask : t_key
    task automatic t_cmds;
        logic [7:0] v;
        op(CMD_ERASE_WR, 1'b0, 0, 8'hff, 8'h47);
        chk(dl[1], OP);
        chk(dl[2], OP);
        chk(dl[6], 1);
        chk(st0[BIT_FLASH_BUSY_BIT], 1'b1);
        target_eeprom <= 1'b1;
        op(CMD_ERASE_WR, 1'b0, 0, 8'hff, 8'h46);
        chk(st0[BIT_EEPROM_BUSY_BIT], 1'b1);
        op(CMD_WRITE, 1'b0, 0, 8'h06, 8'h04);
        op(CMD_ERASE, 1'b0, 0, 8'h06, 8'h02);
        target_protected <= 1'b1;
        op(CMD_ERASE, 1'b0, 0, 8'h06, 8'h00);
        nvc_host_i.rd(ADR_STATUS, v);
        chk(v[BIT_WERR], 1'b1);
    endtask : t_cmds
    task automatic t_chip;
        logic [7:0] v;
        nvc_host_i.wr(ADR_LOCK_CTRL, 8'h03, 1'b0);
        nvc_host_i.rd(ADR_LOCK_CTRL, v);
        chk(v, 8'h03);
        op(CMD_CHIP_ERASE, 1'b0, 0, 8'hbf, 8'h19);
        chk(dl[3], OP);
        eeprom_preserve_fuse <= 1'b1;
        op(CMD_CHIP_ERASE, 1'b0, 0, 8'hbf, 8'h09);
        op(CMD_EE_ERASE, 1'b0, 0, 8'hbf, 8'h21);
        chk(dl[5], OP);
        nvc_host_i.fuse_load(16'h12a4, 16'h00c3);
        op(CMD_FUSE_WR, 1'b0, 0, 8'hff, 8'h00);
        op(CMD_FUSE_WR, 1'b1, 0, 8'h80, 8'h80);
        chk({fuse_addr, fuse_wdata}, 32'h12a4_00c3);
    endtask : t_chip
    task automatic t_sleep;
        logic [7:0] v;
        int b;
        target_protected <= 1'b0;
        nvc_host_i.wr(ADR_IRQ_EN, 8'h01, 1'b0);
        sys_sleep  <= 1'b1;
        sleep_idle <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk({irq_req, wake_req, ctrl_asleep, keep_clk_on}, 4'b1110);
        sleep_idle <= 1'b0;
        b = cnt[6];
        repeat (3) @(posedge clk_sys);
        chk(wake_req, 1'b0);
        sys_sleep <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(cnt[6] - b, 1);
        nvc_host_i.cmd(CMD_ERASE_WR, 1'b0, 0);
        sys_sleep <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk({ctrl_asleep, keep_clk_on}, 2'b01);
        nvc_host_i.wr(ADR_IRQ_FLAGS, 8'h01, 1'b0);
        nvc_host_i.rd(ADR_IRQ_FLAGS, v);
        chk({v[BIT_EE_READY], irq_req}, 2'b00);
        settle();
        chk({irq_req, keep_clk_on}, 2'b10);
        sys_sleep <= 1'b0;
    endtask : t_sleep
    // Reset in mid-erase must stop the sequence before it programs
    task automatic t_abort;
        int b;
        target_eeprom <= 1'b0;
        nvc_host_i.cmd(CMD_ERASE_WR, 1'b0, 0);
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b0;
        @(posedge clk_sys);
        chk({arr_erase, cpu_halt}, 2'b00);
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        b = cnt[2];
        repeat (3) @(posedge clk_sys);
        settle();
        chk(cnt[2] - b, 0);
    endtask : t_abort
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_regs();
        t_key();
        t_cmds();
        t_chip();
        t_sleep();
        t_abort();
        close_out();
    end
endmodule : nvc_ctrl_bench

// ===== nvc_host.sv
// Host model: processor core and debug port on the register port
`timescale 1ns/1ns
module nvc_host
    import nvc_pkg::*;
(
    input  wire  logic       clk_sys,
    output logic [3:0]       reg_addr,
    output logic [7:0]       reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic             reg_from_dbg,
    input  wire  logic [7:0] reg_rdata,
    output logic             key_wr,
    output logic [7:0]       key_data,
    output logic             cpu_insn
);
    // Idle bus at time zero
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, reg_from_dbg} = '0;
        {key_wr, key_data, cpu_insn} = '0;
    end
    // One-cycle write; data lines show the inverse once released
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic dbg);
        @(posedge clk_sys);
        reg_addr     <= a;
        reg_wdata    <= d;
        reg_from_dbg <= dbg;
        reg_wr       <= 1'b1;
        @(posedge clk_sys);
        reg_wr       <= 1'b0;
        reg_wdata    <= ~d;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr     <= a;
        reg_from_dbg <= 1'b0;
        reg_rd       <= 1'b1;
        @(posedge clk_sys);
        reg_rd       <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask : rd
    task automatic cmd(input logic [2:0] c, input logic dbg, input int n);
        @(posedge clk_sys);
        key_wr   <= 1'b1;
        key_data <= SELF_PROG_KEY;
        @(posedge clk_sys);
        key_wr   <= 1'b0;
        key_data <= ~SELF_PROG_KEY;
        repeat (n) begin
            @(posedge clk_sys);
            cpu_insn <= 1'b1;
            @(posedge clk_sys);
            cpu_insn <= 1'b0;
        end
        wr(ADR_CMD_CTRL, {5'h00, c}, dbg);
    endtask : cmd
    task automatic fuse_load(input logic [15:0] a, input logic [15:0] d);
        wr(ADR_ADDR_LO, a[7:0], 1'b1);
        wr(ADR_ADDR_HI, a[15:8], 1'b1);
        wr(ADR_DATA_LO, d[7:0], 1'b1);
        wr(ADR_DATA_HI, d[15:8], 1'b1);
    endtask : fuse_load
endmodule : nvc_host

// ===== nvc_pkg.sv
// Constants for the memory controller command block
package nvc_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses on the plain register port)
    // ------------------------------------------------------------
    localparam logic [3:0] ADR_CMD_CTRL   = 4'h0;
    localparam logic [3:0] ADR_LOCK_CTRL  = 4'h1;
    localparam logic [3:0] ADR_STATUS     = 4'h2;
    localparam logic [3:0] ADR_IRQ_EN     = 4'h3;
    localparam logic [3:0] ADR_IRQ_FLAGS  = 4'h4;
    localparam logic [3:0] ADR_DATA_LO    = 4'h6;
    localparam logic [3:0] ADR_DATA_HI    = 4'h7;
    localparam logic [3:0] ADR_ADDR_LO    = 4'h8;
    localparam logic [3:0] ADR_ADDR_HI    = 4'h9;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         BIT_FLASH_BUSY_BIT      = 0;
    localparam int         BIT_EEPROM_BUSY_BIT     = 1;
    localparam int         BIT_WERR       = 2;
    localparam int         BIT_APP_WP     = 0;
    localparam int         BIT_BOOT_LOCK  = 1;
    localparam int         BIT_EE_READY   = 0;
    localparam logic [7:0] RST_BYTE       = 8'h00;
    localparam logic [7:0] SELF_PROG_KEY  = 8'h9d;   // Arbitrary key value
    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [2:0] CMD_NONE       = 3'h0;
    localparam logic [2:0] CMD_WRITE      = 3'h1;
    localparam logic [2:0] CMD_ERASE      = 3'h2;
    localparam logic [2:0] CMD_ERASE_WR   = 3'h3;
    localparam logic [2:0] CMD_BUF_CLR    = 3'h4;
    localparam logic [2:0] CMD_CHIP_ERASE = 3'h5;
    localparam logic [2:0] CMD_EE_ERASE   = 3'h6;
    localparam logic [2:0] CMD_FUSE_WR    = 3'h7;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int         UNLOCK_WINDOW  = 4;       // Instructions after key
    localparam int         BUF_CLR_CYC    = 7;       // CPU cycles of buffer clear
    localparam int         CLK_MHZ        = 100;
    localparam real        ARRAY_OP_US    = 0.5;     // Default array step time
    localparam int         ARRAY_OP_CYC   = int'(ARRAY_OP_US * CLK_MHZ);
    // Sequencer states
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_ERASE = 6'b000010,
        ST_PROG  = 6'b000100,
        ST_CLEAR = 6'b001000,
        ST_CHIP  = 6'b010000,
        ST_FUSE  = 6'b100000
    } nvc_state_t;
endpackage : nvc_pkg
